// [rtl/rce_encoder.sv]
`timescale 1ns/1ns
`include "rce_map.svh"
// Overview of operation
// - wake on switch, debounce 6.5 ms first
// - hopping code changes every press
// - each bit Manchester coded, one mid transition
// - preamble, header, encrypted, fixed, CRC order
// - packet is exactly 67 bits
// - idle guard gap after every packet
// - encrypted part holds buttons and sync
// - sample low battery, flag in packet
// - repeat packets while any switch held
// - indicator sinks current while transmitting
// - single logic-level data output to radio
module rce_encoder
	import rce_pkg::*;
#(
	parameter int DEB_CYC   = `RCE_DEBOUNCE_CYC,
	parameter int HALF_CYC  = `RCE_HALF_CYC,
	parameter int GUARD_CYC = `RCE_GUARD_CYC,
	parameter logic [31:0] KEY    = `RCE_SEED,
	parameter logic [9:0]  SERIAL = `RCE_SERIAL
) (
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	input  wire logic switch_in_0_i,
	input  wire logic switch_in_1_i,
	input  wire logic switch_in_2_i,
	input  wire logic switch_in_3_i,
	input  wire logic batt_low_i,
	output logic      radio_data_out_o,
	output logic      tx_led_n_o,
	output logic      asleep_o
);
	localparam int PB = `RCE_PKT_BITS;
	logic [4:0]     sw_s1_reg, sw_s2_reg;
	rce_state_t     state_reg, state_next;
	logic [31:0]    cnt_reg, cnt_next;
	logic [6:0]     bit_reg;
	logic           half_reg;
	logic [PB-1:0]  shift_reg;
	logic [15:0]    sync_reg;
	logic           dout_reg;
	logic [31:0]    hop_w;
	logic [7:0]     halves_reg;

	// two-flop synchronisers; stage one read only by stage two
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sw_s1_reg <= 5'h00;
			sw_s2_reg <= 5'h00;
		end else begin
			sw_s1_reg <= {batt_low_i, switch_in_3_i, switch_in_2_i, switch_in_1_i,
				switch_in_0_i};
			sw_s2_reg <= sw_s1_reg;
		end
	end

	wire [3:0] sw_w      = sw_s2_reg[3:0];
	wire       any_sw_w  = |sw_w;
	wire       batt_w    = sw_s2_reg[4];
	wire       cnt_done  = (state_reg == ST_DEB && cnt_reg >= 32'(DEB_CYC - 1))
		|| (state_reg == ST_SEND && cnt_reg >= 32'(HALF_CYC - 1))
		|| (state_reg == ST_GUARD && cnt_reg >= 32'(GUARD_CYC - 1));
	wire       last_bit  = (bit_reg == 7'(PB - 1)) && half_reg;

	// plaintext: buttons, discriminator, sync counter
	rce_cipher #(.W(32)) u_cipher (
		.plain_i  ({sw_w, 12'hABC, sync_reg}),
		.key_i    (KEY),
		.cipher_o (hop_w)
	);

	function automatic logic [1:0] crc2(input logic [`RCE_BODY_BITS-1:0] d);
		logic [1:0] c;
		c = 2'h0;
		for (int i = 0; i < `RCE_BODY_BITS; i++) begin
			c = {c[0], c[1] ^ d[i]};
		end
		return c;
	endfunction

	wire [`RCE_BODY_BITS-1:0] body_w = {hop_w, SERIAL, sw_w, batt_w,
		{`RCE_PAD_BITS{1'b0}}};
	wire [PB-1:0] pkt_w = {{`RCE_PRE_BITS/2{2'b10}}, `RCE_HDR_CODE, body_w,
		crc2(body_w)};
	// first half is the bit itself; on load shift_reg is still stale, so use pkt_w
	wire       dout_next = (state_reg == ST_LOAD) ? pkt_w[PB-1]
		: !cnt_done ? dout_reg
		: half_reg ? shift_reg[PB-2] : ~shift_reg[PB-1];

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 32'h1;
		case (state_reg)
			ST_SLEEP: begin
				cnt_next = 32'h0;
				if (any_sw_w) state_next = ST_DEB;
			end
			ST_DEB: begin
				if (!any_sw_w) begin
					state_next = ST_SLEEP;
					cnt_next   = 32'h0;
				end else if (cnt_done) begin
					state_next = ST_LOAD;
					cnt_next   = 32'h0;
				end
			end
			ST_LOAD: begin
				state_next = ST_SEND;
				cnt_next   = 32'h0;
			end
			ST_SEND: begin
				if (cnt_done) begin
					cnt_next = 32'h0;
					if (last_bit) state_next = ST_GUARD;
				end
			end
			ST_GUARD: begin
				if (cnt_done) begin
					cnt_next   = 32'h0;
					state_next = any_sw_w ? ST_LOAD : ST_SLEEP;
				end
			end
			default: begin
				state_next = ST_SLEEP;
				cnt_next   = 32'h0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= ST_SLEEP;
			cnt_reg   <= 32'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// new hop each packet, so repeats and re-presses always differ
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_reg  <= 16'h0000;
			shift_reg <= '0;
			bit_reg   <= 7'h00;
			half_reg  <= 1'b0;
		end else if (state_reg == ST_LOAD) begin
			sync_reg  <= sync_reg + 16'h1;
			shift_reg <= pkt_w;
			bit_reg   <= 7'h00;
			half_reg  <= 1'b0;
		end else if (state_reg == ST_SEND && cnt_done) begin
			half_reg <= ~half_reg;
			if (half_reg) begin
				bit_reg   <= bit_reg + 7'h1;
				shift_reg <= {shift_reg[PB-2:0], 1'b0};
			end
		end
	end

	// check-only tally of half periods, independent of bit_reg
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			halves_reg <= 8'h00;
		end else if (state_reg == ST_LOAD) begin
			halves_reg <= 8'h00;
		end else if (state_reg == ST_SEND && cnt_done) begin
			halves_reg <= halves_reg + 8'h1;
		end
	end

	// bit 1 = high then low, bit 0 = low then high
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dout_reg <= 1'b0;
		end else if (state_next == ST_SEND) begin
			dout_reg <= dout_next;
		end else begin
			dout_reg <= 1'b0;
		end
	end

	assign radio_data_out_o = dout_reg;
	assign tx_led_n_o       = !(state_reg == ST_SEND || state_reg == ST_LOAD);
	assign asleep_o         = (state_reg == ST_SLEEP);

	a_guard_idle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_GUARD |-> !radio_data_out_o)
		else $error("data not idle in guard");
	a_led_on_send: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_SEND |-> !tx_led_n_o)
		else $error("led off while sending");
	sequence s_wake_to_load;
		state_reg == ST_SLEEP ##1 state_reg == ST_LOAD;
	endsequence
	a_wake_deb: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		s_wake_to_load |-> 1'b0)
		else $error("skipped debounce");
	a_sync_step: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_LOAD |=> sync_reg == $past(sync_reg) + 16'h1)
		else $error("hop counter did not advance");
	a_pkt_len: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_SEND && state_next == ST_GUARD |-> bit_reg == 7'(PB - 1))
		else $error("packet length wrong");
	a_repeat_held: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_GUARD && cnt_done && any_sw_w |=> state_reg == ST_LOAD)
		else $error("no repeat while held");
	a_sleep_rel: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_GUARD && cnt_done && !any_sw_w |=> asleep_o)
		else $error("no sleep after release");
	a_mid_trans: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_SEND && cnt_done && !half_reg |=> radio_data_out_o != $past(dout_reg))
		else $error("no mid-bit transition");
	a_half_count: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_SEND && state_next == ST_GUARD |-> halves_reg == 8'(2 * PB - 1))
		else $error("wrong number of half bits");
	a_led_idle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_SLEEP || state_reg == ST_DEB |-> tx_led_n_o)
		else $error("led on while not sending");
	a_batt_flag: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_LOAD |=> shift_reg[`RCE_BATT_POS] == $past(batt_w))
		else $error("battery flag not in packet");
endmodule

// [rtl/rce_map.svh]
`ifndef RCE_MAP_SVH
`define RCE_MAP_SVH
`define RCE_CLK_HZ        25000000
`define RCE_DEBOUNCE_NS   6500000
`define RCE_DEBOUNCE_CYC  ((`RCE_DEBOUNCE_NS * 25) / 1000)
`define RCE_PKT_BITS      67
`define RCE_PRE_BITS      12
`define RCE_HDR_BITS      4
`define RCE_HOP_BITS      32
`define RCE_SER_BITS      10
`define RCE_CRC_BITS      2
`define RCE_PAD_BITS      2
`define RCE_BODY_BITS     49
`define RCE_BATT_POS      4
`define RCE_HALF_CYC      5000
`define RCE_GUARD_CYC     100000
`define RCE_SEED          32'h1234ABCD
`define RCE_SERIAL        10'h2A5
`define RCE_HDR_CODE      4'h0
`endif

// [rtl/rce_pkg.sv]
package rce_pkg;
	typedef enum logic [4:0] {
		ST_SLEEP = 5'h01,
		ST_DEB   = 5'h02,
		ST_LOAD  = 5'h04,
		ST_SEND  = 5'h08,
		ST_GUARD = 5'h10
	} rce_state_t;
endpackage

// [rtl/rce_cipher.sv]
`timescale 1ns/1ns
// replaceable stub: cheap mixing, not a secure cipher
module rce_cipher
	import rce_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic [W-1:0] plain_i,
	input  wire logic [W-1:0] key_i,
	output logic      [W-1:0] cipher_o
);
	wire [W-1:0] mix1 = plain_i ^ key_i;
	wire [W-1:0] rot  = {mix1[W-6:0], mix1[W-1:W-5]};
	assign cipher_o = rot + {key_i[W/2-1:0], key_i[W-1:W/2]};
endmodule

// [dv/rce_radio_rx.sv]
`timescale 1ns/1ns
// passive radio input: decodes half bits at their middles
module rce_radio_rx #(
	parameter int HALF = 4
) (
	input  wire logic        clk_i,
	input  wire logic        data_i,
	output logic      [66:0] pkt_o,
	output logic             pkt_ok_o,
	output logic             pkt_vld_o
);
	logic a;
	initial begin
		pkt_vld_o = 1'b0;
		pkt_ok_o = 1'b1;
		pkt_o = '0;
		forever begin
			@(posedge data_i);
			pkt_ok_o = 1'b1;
			repeat (HALF / 2) @(posedge clk_i);
			for (int i = 66; i >= 0; i--) begin
				a = data_i;
				repeat (HALF) @(posedge clk_i);
				if (data_i === a) pkt_ok_o = 1'b0;
				pkt_o[i] = a;
				repeat (HALF) @(posedge clk_i);
			end
			pkt_vld_o = 1'b1;
			@(posedge clk_i);
			pkt_vld_o = 1'b0;
		end
	end
endmodule

// [dv/test_rce_encoder.sv]
`timescale 1ns/1ns
module test_rce_encoder;
	import rce_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [3:0]  sw = 4'h0;
	logic        batt = 1'b0;
	logic        data_o, led_n, asleep, pkt_ok, pkt_vld;
	logic [66:0] pkt;
	logic [31:0] last_hop = 32'h0;
	logic [30:0] exp_q[$];
	int          bad_count = 0;
	int          n_compared = 0;
	int          seed = 72;
	always #20 ref_clk_i = ~ref_clk_i;
	rce_encoder #(.DEB_CYC(20), .HALF_CYC(4), .GUARD_CYC(30)) i_dut (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.switch_in_0_i(sw[0]), .switch_in_1_i(sw[1]),
		.switch_in_2_i(sw[2]), .switch_in_3_i(sw[3]),
		.batt_low_i(batt), .radio_data_out_o(data_o),
		.tx_led_n_o(led_n), .asleep_o(asleep));
	rce_radio_rx #(.HALF(4)) i_rx (.clk_i(ref_clk_i), .data_i(data_o),
		.pkt_o(pkt), .pkt_ok_o(pkt_ok), .pkt_vld_o(pkt_vld));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic conclude();
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// n = packets that start within the hold time with the shortened counts
	task automatic press(input logic [3:0] b, input int hold, input int n);
		@(posedge ref_clk_i);
		#5;
		sw = (b == 4'h0) ? 4'h1 : b;
		batt = 1'($random(seed));
		repeat (n) exp_q.push_back({12'hAAA, 4'h0, 10'h2A5, sw, batt});
		if (hold >= 30) begin
			repeat (20) @(posedge ref_clk_i);
			#5;
			check(data_o, 1'b0);
			check(asleep, 1'b0);
			repeat (10) @(posedge ref_clk_i);
			#5;
			check(led_n, 1'b0);
			repeat (hold - 30) @(posedge ref_clk_i);
		end else begin
			repeat (hold) @(posedge ref_clk_i);
		end
		#5 sw = 4'h0;
		repeat (700) @(posedge ref_clk_i);
		#5;
		check(asleep, 1'b1);
		check(data_o, 1'b0);
	endtask
	// a packet with no note left is an extra repeat; lamp is off again in guard
	always @(posedge pkt_vld) begin
		check(exp_q.size() != 0, 1'b1);
		if (exp_q.size() != 0)
			check({pkt[66:51], pkt[18:4]}, exp_q.pop_front());
		check(pkt_ok, 1'b1);
		check(pkt[50:19] != last_hop, 1'b1);
		check(led_n, 1'b1);
		last_hop = pkt[50:19];
	end
	// data high while the lamp is dark means the indicator missed a send
	always @(negedge ref_clk_i) begin
		if (data_o === 1'b1) check(led_n, 1'b0);
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		#5 nrst_i = 1'b1;
		check(asleep, 1'b1);
		press(4'h5, 8, 0);
		press(4'h3, 700, 2);
		press(4'h3, 700, 2);
		for (int k = 0; k < 3; k++)
			press(4'($random(seed)), 700, 2);
		check(exp_q.size(), 0);
		conclude();
	end
	initial begin
		repeat (10000) @(posedge ref_clk_i);
		bad_count++;
		conclude();
	end
endmodule
